//--- qec_counter_group.sv
// Quadrature encoder counter group: four counter channels latched into the scan stream
`default_nettype none

module qec_counter_group #(
  parameter int unsigned TICK_LONG_CYC = qec_pkg::TICK_LONG_CYC
) (
  input  wire logic                                 clk_i,
  input  wire logic                                 srst_i,
  input  wire logic                                 counter_input_zero_i,
  input  wire logic                                 counter_input_one_i,
  input  wire logic                                 counter_input_two_i,
  input  wire logic                                 counter_input_three_i,
  input  wire logic                                 scan_begin_marker_i,
  input  wire logic                                 acq_start_i,
  input  wire logic                                 acq_stop_i,
  input  wire qec_pkg::qec_cfg_type [qec_pkg::NUM_CH-1:0] cfg_i,
  output qec_pkg::qec_scan_type                     scan_data_o,
  output logic                                      scan_latched_o,
  output logic                                      acq_running_o
);

  localparam int N = qec_pkg::NUM_CH;

  typedef struct packed {
    qec_pkg::qec_acq_type                  acq;
    logic [N-1:0]                          lvl_prev;
    logic [N-1:0][qec_pkg::CNT_W-1:0]      cnt;
    logic [N-1:0][qec_pkg::CNT_W-1:0]      per_val;
    logic [N-1:0][qec_pkg::TICK_W-1:0]     tick_cnt;
    logic [N-1:0]                          ref_seen;
    qec_pkg::qec_scan_type                 latched;
    logic                                  latch_pulse;
  } qec_state_type;

  qec_state_type s_q;
  qec_state_type s_d;

  logic [N-1:0] raw;
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;

  assign raw = {counter_input_three_i, counter_input_two_i, counter_input_one_i, counter_input_zero_i};

  // One debounce filter per input, each with its own time
  for (genvar g = 0; g < N; g++) begin : g_db
    qec_debounce u_db (
      .clk_i    (clk_i),
      .srst_i   (srst_i),
      .raw_i    (raw[g]),
      .db_sel_i (cfg_i[g].db_sel),
      .level_o  (lvl[g])
    );
  end

  // Edges of the filtered inputs
  assign rise = lvl & ~s_q.lvl_prev;
  assign fall = ~lvl & s_q.lvl_prev;

  // Clock cycles per period-mode tick
  function automatic logic [qec_pkg::TICK_W-1:0] tick_limit(input qec_pkg::qec_tick_type sel);
    case (sel)
      qec_pkg::QEC_TICK_SHORT: tick_limit = qec_pkg::TICK_W'(qec_pkg::TICK_SHORT_CYC);
      qec_pkg::QEC_TICK_MID:   tick_limit = qec_pkg::TICK_W'(qec_pkg::TICK_MID_CYC);
      qec_pkg::QEC_TICK_LONG:  tick_limit = qec_pkg::TICK_W'(TICK_LONG_CYC);
      default:                 tick_limit = qec_pkg::TICK_ONE;
    endcase
  endfunction : tick_limit

  // Channel value presented to the latch: last full period, or the counter
  function automatic logic [qec_pkg::CNT_W-1:0] chan_value(input qec_state_type s, input int i,
                                                           input qec_pkg::qec_mode_type m);
    chan_value = (m == qec_pkg::QEC_MODE_PERIOD) ? s.per_val[i] : s.cnt[i];
  endfunction : chan_value

  // Next-state logic for all channels
  always_comb begin
    logic       a_now;
    logic       b_now;
    logic       a_old;
    logic       b_old;
    logic       m_lvl;
    logic       m_rise;
    logic       step;
    logic       up;
    logic       tick;
    logic [1:0] part;
    a_now  = 1'b0;
    b_now  = 1'b0;
    a_old  = 1'b0;
    b_old  = 1'b0;
    m_lvl  = 1'b0;
    m_rise = 1'b0;
    step   = 1'b0;
    up     = 1'b0;
    tick   = 1'b0;
    part   = 2'h0;
    s_d             = s_q;
    s_d.lvl_prev    = lvl;
    s_d.latch_pulse = 1'b0;

    for (int i = 0; i < N; i++) begin
      // Partner input: the even/odd pair decodes together
      part  = 2'(i) ^ 2'h1;
      a_now = lvl[i];
      b_now = lvl[part];
      a_old = s_q.lvl_prev[i];
      b_old = s_q.lvl_prev[part];
      m_lvl  = lvl[cfg_i[i].map_sel];
      m_rise = rise[cfg_i[i].map_sel];

      // Count events per resolution option; up when A leads B
      case (cfg_i[i].enc_opt)
        qec_pkg::QEC_ENC_X1: step = rise[i];
        qec_pkg::QEC_ENC_X2: step = rise[i] | fall[i];
        qec_pkg::QEC_ENC_X4: step = (rise[i] | fall[i]) | (b_now ^ b_old);
        default:             step = rise[i];
      endcase
      if (a_now != a_old) begin
        up = a_now ^ b_old;
      end else begin
        up = ~(b_now ^ a_now);
      end

      // Tick divider for period mode
      tick = 1'b0;
      if (s_q.tick_cnt[i] + qec_pkg::TICK_ONE >= tick_limit(cfg_i[i].tick_sel)) begin
        s_d.tick_cnt[i] = qec_pkg::TICK_ZERO;
        tick            = 1'b1;
      end else begin
        s_d.tick_cnt[i] = s_q.tick_cnt[i] + qec_pkg::TICK_ONE;
      end

      if (s_q.acq == qec_pkg::QEC_ACQ_RUN) begin
        case (cfg_i[i].mode)
          qec_pkg::QEC_MODE_ENC: begin
            // Gate holds the count while the mapped input is low
            if (step && (!cfg_i[i].gate_en || m_lvl)) begin
              s_d.cnt[i] = up ? s_q.cnt[i] + qec_pkg::CNT_ONE : s_q.cnt[i] - qec_pkg::CNT_ONE;
            end
          end
          qec_pkg::QEC_MODE_PERIOD: begin
            // Ticks between rising edges; the mapped input never gates here
            if (rise[i]) begin
              s_d.per_val[i]  = s_q.cnt[i];
              s_d.cnt[i]      = qec_pkg::CNT_ZERO;
              s_d.tick_cnt[i] = qec_pkg::TICK_ZERO;
            end else if (tick && s_q.cnt[i] != qec_pkg::CNT_MAX) begin
              s_d.cnt[i] = s_q.cnt[i] + qec_pkg::CNT_ONE;
            end
          end
          default: begin
            // Totalize: stops at the top rather than wrapping
            if (rise[i] && (!cfg_i[i].gate_en || m_lvl) && s_q.cnt[i] != qec_pkg::CNT_MAX) begin
              s_d.cnt[i] = s_q.cnt[i] + qec_pkg::CNT_ONE;
            end
          end
        endcase

        // Mapped rising edge clears; also marks the index reference as found
        if (cfg_i[i].clear_en && m_rise && cfg_i[i].mode != qec_pkg::QEC_MODE_PERIOD) begin
          s_d.cnt[i]      = qec_pkg::CNT_ZERO;
          s_d.ref_seen[i] = 1'b1;
        end
      end
    end

    // Scan start latches every channel; value covers the scan just ended
    if (s_q.acq == qec_pkg::QEC_ACQ_RUN && scan_begin_marker_i) begin
      for (int i = 0; i < N; i++) begin
        s_d.latched.count[i]     = chan_value(s_q, i, cfg_i[i].mode);
        s_d.latched.ref_valid[i] = s_q.ref_seen[i];
      end
      s_d.latch_pulse = 1'b1;
    end

    // Acquisition control; start wins over everything and zeroes all channels
    case (s_q.acq)
      qec_pkg::QEC_ACQ_IDLE: begin
        if (acq_start_i) begin
          s_d.acq = qec_pkg::QEC_ACQ_RUN;
        end
      end
      qec_pkg::QEC_ACQ_RUN: begin
        if (acq_stop_i && !acq_start_i) begin
          s_d.acq = qec_pkg::QEC_ACQ_IDLE;
        end
      end
      default: s_d.acq = qec_pkg::QEC_ACQ_IDLE;
    endcase
    if (acq_start_i) begin
      s_d.cnt         = '0;
      s_d.per_val     = '0;
      s_d.tick_cnt    = '0;
      s_d.ref_seen    = '0;
      s_d.latched     = '0;
      s_d.latch_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign scan_data_o    = s_q.latched;
  assign scan_latched_o = s_q.latch_pulse;
  assign acq_running_o  = (s_q.acq == qec_pkg::QEC_ACQ_RUN);

  // Checks
  logic run;
  assign run = (s_q.acq == qec_pkg::QEC_ACQ_RUN);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_START_CLEARS: assert property (acq_start_i |=> (s_q.cnt == '0) && (scan_data_o == '0) ##1 run)
    else $error("acquisition start did not clear counters");
  AST_SOS_LATCH: assert property (run && scan_begin_marker_i && !acq_start_i
      |=> scan_latched_o && scan_data_o.count[0] == $past(chan_value(s_q, 0, cfg_i[0].mode)))
    else $error("scan start did not latch channel zero");
  AST_LATCH_HOLD: assert property (!scan_latched_o && !$past(acq_start_i)
      |-> $stable(scan_data_o))
    else $error("latched data changed without a latch");
  AST_TOTAL_SAT: assert property (run && cfg_i[2].mode == qec_pkg::QEC_MODE_TOTAL && !cfg_i[2].clear_en
      && s_q.cnt[2] == qec_pkg::CNT_MAX && !acq_start_i |=> s_q.cnt[2] == qec_pkg::CNT_MAX)
    else $error("totalize counter rolled over");
  AST_INDEX_CLEAR: assert property (run && cfg_i[0].mode == qec_pkg::QEC_MODE_ENC && cfg_i[0].clear_en
      && rise[cfg_i[0].map_sel] && !acq_start_i |=> s_q.cnt[0] == '0 && s_q.ref_seen[0])
    else $error("mapped rising edge did not clear the counter");
  AST_GATE_HOLD: assert property (run && cfg_i[0].mode == qec_pkg::QEC_MODE_ENC && cfg_i[0].gate_en
      && !lvl[cfg_i[0].map_sel] && !(cfg_i[0].clear_en && rise[cfg_i[0].map_sel]) && !acq_start_i
      |=> $stable(s_q.cnt[0]))
    else $error("gated counter moved while gate low");
  AST_REF_CAUSE: assert property ($rose(s_q.ref_seen[0])
      |-> $past(rise[cfg_i[0].map_sel] && cfg_i[0].clear_en))
    else $error("index reference flagged without an index edge");
  AST_UP_4X: assert property (run && cfg_i[0].mode == qec_pkg::QEC_MODE_ENC && cfg_i[0].enc_opt == qec_pkg::QEC_ENC_X4
      && !cfg_i[0].gate_en && !cfg_i[0].clear_en && !acq_start_i && rise[0] && !lvl[1] && !s_q.lvl_prev[1]
      |=> s_q.cnt[0] == $past(s_q.cnt[0]) + qec_pkg::CNT_ONE)
    else $error("leading phase A did not count up");
  AST_X1_FALL: assert property (run && cfg_i[0].mode == qec_pkg::QEC_MODE_ENC && cfg_i[0].enc_opt == qec_pkg::QEC_ENC_X1
      && !cfg_i[0].clear_en && !acq_start_i && fall[0] |=> $stable(s_q.cnt[0]))
    else $error("1X counted a falling edge");
  AST_PERIOD_CAP: assert property (run && cfg_i[1].mode == qec_pkg::QEC_MODE_PERIOD && rise[1] && !acq_start_i
      |=> s_q.per_val[1] == $past(s_q.cnt[1]) && s_q.cnt[1] == '0)
    else $error("period not captured on rising edge");

  COV_LATCH: cover property (run && scan_begin_marker_i ##1 scan_latched_o);
  COV_INDEX: cover property (run && cfg_i[0].clear_en && rise[cfg_i[0].map_sel]);
  COV_PERIOD: cover property (run && cfg_i[1].mode == qec_pkg::QEC_MODE_PERIOD && rise[1]);
  COV_SAT: cover property (run && s_q.cnt[2] == qec_pkg::CNT_MAX);

endmodule : qec_counter_group

`default_nettype wire

//--- qec_pkg.sv
// Shared constants, types and channel configuration for the quadrature encoder counter group
`default_nettype none

package qec_pkg;

  // Channel count and counter geometry
  localparam int          NUM_CH  = 4;
  localparam int          CNT_W   = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_MAX  = 16'hffff;

  // Clock period in picoseconds (200 MHz)
  localparam int CLK_PERIOD_PS = 5000;

  // Period-mode tick sizes in picoseconds, as printed
  localparam int TICK_SHORT_PS = 208300;
  localparam int TICK_MID_PS   = 2083300;
  localparam int TICK_LONG_PS  = 20833000;
  localparam int TICK_SHORT_CYC = (TICK_SHORT_PS / CLK_PERIOD_PS < 1) ? 1 : TICK_SHORT_PS / CLK_PERIOD_PS;
  localparam int TICK_MID_CYC   = (TICK_MID_PS / CLK_PERIOD_PS < 1) ? 1 : TICK_MID_PS / CLK_PERIOD_PS;
  localparam int TICK_LONG_CYC  = (TICK_LONG_PS / CLK_PERIOD_PS < 1) ? 1 : TICK_LONG_PS / CLK_PERIOD_PS;
  localparam int TICK_W         = 13;
  localparam logic [12:0] TICK_ZERO = 13'h0000;
  localparam logic [12:0] TICK_ONE  = 13'h0001;

  // Debounce times in nanoseconds; least times, rounded up to cycles
  localparam int DB_SHORT_NS = 500;
  localparam int DB_MID_NS   = 1000;
  localparam int DB_LONG_NS  = 2000;
  localparam int DB_SHORT_CYC = (DB_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DB_MID_CYC   = (DB_MID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DB_LONG_CYC  = (DB_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DB_W         = 9;
  localparam logic [8:0] DB_ZERO = 9'h000;
  localparam logic [8:0] DB_ONE  = 9'h001;

  // Channel counting mode
  typedef enum logic [1:0] {
    QEC_MODE_TOTAL  = 2'h0,
    QEC_MODE_ENC    = 2'h1,
    QEC_MODE_PERIOD = 2'h3
  } qec_mode_type;

  // Encoder resolution option
  typedef enum logic [1:0] {
    QEC_ENC_X1 = 2'h0,
    QEC_ENC_X2 = 2'h1,
    QEC_ENC_X4 = 2'h3
  } qec_enc_type;

  // Period tick size select
  typedef enum logic [1:0] {
    QEC_TICK_SHORT = 2'h0,
    QEC_TICK_MID   = 2'h1,
    QEC_TICK_LONG  = 2'h3
  } qec_tick_type;

  // Debounce select; off passes the input straight through
  typedef enum logic [1:0] {
    QEC_DB_OFF   = 2'h0,
    QEC_DB_SHORT = 2'h1,
    QEC_DB_MID   = 2'h3,
    QEC_DB_LONG  = 2'h2
  } qec_db_type;

  // Acquisition state
  typedef enum logic [0:0] {
    QEC_ACQ_IDLE = 1'b0,
    QEC_ACQ_RUN  = 1'b1
  } qec_acq_type;

  // Per-channel configuration
  typedef struct packed {
    qec_mode_type mode;
    qec_enc_type  enc_opt;
    logic         gate_en;
    logic         clear_en;
    logic [1:0]   map_sel;
    qec_tick_type tick_sel;
    qec_db_type   db_sel;
  } qec_cfg_type;

  // Latched scan data handed to the scan sequencer
  typedef struct packed {
    logic [NUM_CH-1:0][CNT_W-1:0] count;
    logic [NUM_CH-1:0]            ref_valid;
  } qec_scan_type;

endpackage : qec_pkg

`default_nettype wire

//--- qec_debounce.sv
// Per-input debounce filter with a selectable stability time
`default_nettype none

module qec_debounce (
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic               raw_i,
  input  wire qec_pkg::qec_db_type db_sel_i,
  output logic                    level_o
);

  typedef struct packed {
    logic                      level;
    logic [qec_pkg::DB_W-1:0]  cnt;
  } qec_db_state_type;

  qec_db_state_type s_q;
  qec_db_state_type s_d;

  // Stability count for the chosen time
  function automatic logic [qec_pkg::DB_W-1:0] db_limit(input qec_pkg::qec_db_type sel);
    case (sel)
      qec_pkg::QEC_DB_SHORT: db_limit = qec_pkg::DB_W'(qec_pkg::DB_SHORT_CYC);
      qec_pkg::QEC_DB_MID:   db_limit = qec_pkg::DB_W'(qec_pkg::DB_MID_CYC);
      qec_pkg::QEC_DB_LONG:  db_limit = qec_pkg::DB_W'(qec_pkg::DB_LONG_CYC);
      default:               db_limit = qec_pkg::DB_ONE;
    endcase
  endfunction : db_limit

  // Unless debounce is off, level follows the raw input only once it has held steady; vibration edges die here
  always_comb begin
    s_d = s_q;
    if (db_sel_i == qec_pkg::QEC_DB_OFF) begin
      s_d.level = raw_i;
      s_d.cnt   = qec_pkg::DB_ZERO;
    end else if (raw_i != s_q.level) begin
      if (s_q.cnt + qec_pkg::DB_ONE >= db_limit(db_sel_i)) begin
        s_d.level = raw_i;
        s_d.cnt   = qec_pkg::DB_ZERO;
      end else begin
        s_d.cnt = s_q.cnt + qec_pkg::DB_ONE;
      end
    end else begin
      s_d.cnt = qec_pkg::DB_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.level;

endmodule : qec_debounce

`default_nettype wire

//--- qec_enc_model.sv
// Partner model: quadrature encoder with index output, plus the scan start source
`default_nettype none

module qec_enc_model (
  input  wire logic clk_i,
  output var logic  phase_a_o,
  output var logic  phase_b_o,
  output var logic  index_o,
  output var logic  scan_mark_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int phase_q = 0;

  initial begin
    phase_a_o   = 1'b0;
    phase_b_o   = 1'b0;
    index_o     = 1'b0;
    scan_mark_o = 1'b0;
  end

  // One quadrature step, then dwell; forward makes A lead B
  task automatic step(input bit fwd, input int dwell);
    @(negedge clk_i);
    phase_q = fwd ? (phase_q + 1) % 4 : (phase_q + 3) % 4;
    phase_a_o = (phase_q == 1) || (phase_q == 2);
    phase_b_o = (phase_q == 2) || (phase_q == 3);
    repeat (dwell - 1) @(negedge clk_i);
  endtask : step

  // Index mark, once per revolution
  task automatic index_pulse();
    @(negedge clk_i);
    index_o = 1'b1;
    repeat (3) @(negedge clk_i);
    index_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : index_pulse

  // Start-of-scan strobe, exactly one cycle wide
  task automatic mark();
    @(negedge clk_i);
    scan_mark_o = 1'b1;
    @(negedge clk_i);
    scan_mark_o = 1'b0;
  endtask : mark
endmodule : qec_enc_model

`default_nettype wire

//--- tb_top.sv
// Testbench for the quadrature encoder counter group
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int STEP = 50;
  localparam int CEIL = 40000;

  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic acq_start_i = 1'b0;
  logic acq_stop_i = 1'b0;
  logic in_three = 1'b0;
  logic pa, pb, pz, scan_begin_marker;
  qec_pkg::qec_cfg_type [qec_pkg::NUM_CH-1:0] cfg_i;
  qec_pkg::qec_scan_type scan_data_o;
  logic scan_latched_o, acq_running_o;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  initial forever #2.5 clk_i = ~clk_i;

  qec_enc_model i_qec_enc_model (.clk_i(clk_i), .phase_a_o(pa), .phase_b_o(pb), .index_o(pz), .scan_mark_o(scan_begin_marker));

  // A on the even input, B on the next odd one, index on input two
  qec_counter_group #(.TICK_LONG_CYC(50)) i_qec_counter_group (
    .clk_i                (clk_i),
    .srst_i               (srst_i),
    .counter_input_zero_i (pa),
    .counter_input_one_i  (pb),
    .counter_input_two_i  (pz),
    .counter_input_three_i(in_three),
    .scan_begin_marker_i  (scan_begin_marker),
    .acq_start_i          (acq_start_i),
    .acq_stop_i           (acq_stop_i),
    .cfg_i                (cfg_i),
    .scan_data_o          (scan_data_o),
    .scan_latched_o       (scan_latched_o),
    .acq_running_o        (acq_running_o)
  );

  function automatic qec_pkg::qec_cfg_type mk(qec_pkg::qec_mode_type m, qec_pkg::qec_enc_type e, logic g, logic c,
                                              logic [1:0] s, qec_pkg::qec_db_type d);
    mk = '{mode: m, enc_opt: e, gate_en: g, clear_en: c, map_sel: s, tick_sel: qec_pkg::QEC_TICK_SHORT, db_sel: d};
  endfunction : mk

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Acquisition start pulse, counters cleared
  task automatic start_acq();
    @(negedge clk_i);
    acq_start_i = 1'b1;
    @(negedge clk_i);
    acq_start_i = 1'b0;
    chk("running", 16'h0001, {15'h0000, acq_running_o});
    for (int i = 0; i < 4; i++) chk("count after start", 16'h0000, scan_data_o.count[i]);
  endtask : start_acq

  // Scan mark, latch pulse expected only while running
  task automatic scan(input logic exp_pulse);
    i_qec_enc_model.mark();
    chk("latch pulse", {15'h0000, exp_pulse}, {15'h0000, scan_latched_o});
  endtask : scan

  task automatic steps(input int n, input bit fwd);
    repeat (n) i_qec_enc_model.step(fwd, STEP);
  endtask : steps

  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == CEIL) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    cfg_i[0] = mk(qec_pkg::QEC_MODE_ENC, qec_pkg::QEC_ENC_X4, 1'b0, 1'b1, 2'h2, qec_pkg::QEC_DB_OFF);
    cfg_i[1] = mk(qec_pkg::QEC_MODE_PERIOD, qec_pkg::QEC_ENC_X1, 1'b0, 1'b0, 2'h0, qec_pkg::QEC_DB_OFF);
    cfg_i[2] = mk(qec_pkg::QEC_MODE_TOTAL, qec_pkg::QEC_ENC_X1, 1'b0, 1'b0, 2'h0, qec_pkg::QEC_DB_OFF);
    cfg_i[3] = mk(qec_pkg::QEC_MODE_TOTAL, qec_pkg::QEC_ENC_X1, 1'b0, 1'b0, 2'h0, qec_pkg::QEC_DB_SHORT);
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    chk("running after reset", 16'h0000, {15'h0000, acq_running_o});
    scan(1'b0); // Marker while idle is ignored
    start_acq();
    // Forward motion, 4X; B rises every 4*STEP cycles giving 4 short ticks
    steps(8, 1'b1);
    scan(1'b1);
    chk("position fwd", 16'h0008, scan_data_o.count[0]);
    chk("period ticks", 16'h0004, scan_data_o.count[1]);
    chk("ref before index", 16'h0000, {15'h0000, scan_data_o.ref_valid[0]});
    steps(3, 1'b0);
    chk("held latch", 16'h0008, scan_data_o.count[0]);
    scan(1'b1);
    chk("position back", 16'h0005, scan_data_o.count[0]);
    // Index clears position and is totalled
    i_qec_enc_model.index_pulse();
    scan(1'b1);
    chk("position cleared", 16'h0000, scan_data_o.count[0]);
    chk("ref after index", 16'h0001, {15'h0000, scan_data_o.ref_valid[0]});
    chk("revolutions", 16'h0001, scan_data_o.count[2]);
    // One full quadrature cycle at each resolution
    for (int k = 0; k < 3; k++) begin
      cfg_i[0] = mk(qec_pkg::QEC_MODE_ENC, k == 0 ? qec_pkg::QEC_ENC_X1 : k == 1 ? qec_pkg::QEC_ENC_X2 :
                    qec_pkg::QEC_ENC_X4, 1'b0, 1'b0, 2'h2, qec_pkg::QEC_DB_OFF);
      start_acq();
      scan(1'b1);
      chk("first scan zero", 16'h0000, scan_data_o.count[0]);
      steps(4, 1'b1);
      scan(1'b1);
      chk("resolution", 16'h0001 << k, scan_data_o.count[0]);
      chk("ref cleared", 16'h0000, {15'h0000, scan_data_o.ref_valid[0]});
    end
    // Gate from debounced input three; a short glitch must not pass
    cfg_i[0] = mk(qec_pkg::QEC_MODE_ENC, qec_pkg::QEC_ENC_X4, 1'b1, 1'b0, 2'h3, qec_pkg::QEC_DB_OFF);
    start_acq();
    in_three = 1'b1;
    repeat (50) @(negedge clk_i);
    in_three = 1'b0;
    steps(4, 1'b1);
    scan(1'b1);
    chk("gated off", 16'h0000, scan_data_o.count[0]);
    chk("glitch filtered", 16'h0000, scan_data_o.count[3]);
    in_three = 1'b1;
    repeat (qec_pkg::DB_SHORT_CYC + 10) @(negedge clk_i);
    steps(4, 1'b1);
    scan(1'b1);
    chk("gated on", 16'h0004, scan_data_o.count[0]);
    chk("filtered edge", 16'h0001, scan_data_o.count[3]);
    // Stop: markers refused, data held
    @(negedge clk_i);
    acq_stop_i = 1'b1;
    @(negedge clk_i);
    acq_stop_i = 1'b0;
    chk("stopped", 16'h0000, {15'h0000, acq_running_o});
    scan(1'b0);
    chk("held after stop", 16'h0004, scan_data_o.count[0]);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
